// File: design/pcr_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef PCR_REGS_VH
`define PCR_REGS_VH

// ****************************************
// Register indices and byte addresses
// ****************************************
`define PCR_IDX_CTRL1 8'h09
`define PCR_IDX_CTRL2 8'h0A
`define PCR_ADDR_CTRL1 12'h024
`define PCR_ADDR_CTRL2 12'h028
`define PCR_ADDR_STATUS 12'h030
`define PCR_ADDR_LINK 12'h034

// ****************************************
// First control register fields
// ****************************************
`define PCR_C1_FAST_MDIX 6
`define PCR_C1_ROBUST_MDIX 5
`define PCR_C1_FAST_AN 4
`define PCR_C1_AN_SEL_HI 3
`define PCR_C1_AN_SEL_LO 2
`define PCR_C1_FAST_RXDV 1
`define PCR_C1_RESET 16'h0000
`define PCR_C1_WMASK 16'h007E

// ****************************************
// Second control register fields
// ****************************************
`define PCR_C2_FAR_DROP 15
`define PCR_C2_FX_EN 14
`define PCR_C2_FAST_PD 6
`define PCR_C2_EXT_FD 5
`define PCR_C2_LED_ENH 4
`define PCR_C2_ISO_MII 3
`define PCR_C2_IDLE_ERR 2
`define PCR_C2_ODD_DIS 1
`define PCR_C2_RMII_RXCLK 0
`define PCR_C2_RESET 16'h0100
`define PCR_C2_WMASK 16'hC07F

// ****************************************
// Timer figures in milliseconds, clock in kilohertz
// ****************************************
`define PCR_LFI_MS_0 50
`define PCR_LFI_MS_1 75
`define PCR_LFI_MS_2 150
`define PCR_LFI_MS_STD 750
`define PCR_CLK_KHZ 20000
// Edges from reset release until the synchronised strap is loaded
`define PCR_STRAP_WAIT 2'h3

`endif

// File: design/pcr_apb_slave.v
// APB slave front end: decode, zero-wait answer, error on unmapped address
`timescale 1ns/10ps
module pcr_apb_slave (
  // Bus
  input wire psel,
  input wire penable,
  input wire [11:0] paddr,
  output wire pready,
  output wire pslverr,
  // Decoded strobes and the bus write flag
  output wire wr_ctrl1,
  output wire wr_ctrl2,
  output wire [1:0] rd_sel,
  output wire rd_hit,
  input wire pwrite
);
  `include "pcr_regs.vh"
  wire hit1;
  wire hit2;
  wire hit3;
  wire hit4;
  wire access;
  assign hit1 = (paddr == `PCR_ADDR_CTRL1);
  assign hit2 = (paddr == `PCR_ADDR_CTRL2);
  assign hit3 = (paddr == `PCR_ADDR_STATUS);
  assign hit4 = (paddr == `PCR_ADDR_LINK);
  assign access = psel & penable;
  // Zero wait states keep the register path simple
  assign pready = 1'b1;
  assign rd_hit = hit1 | hit2 | hit3 | hit4;
  assign pslverr = access & ~rd_hit;
  assign wr_ctrl1 = access & pwrite & hit1;
  assign wr_ctrl2 = access & pwrite & hit2;
  assign rd_sel = hit1 ? 2'h0 : hit2 ? 2'h1 : hit3 ? 2'h2 : 2'h3;
endmodule

// File: design/pcr_sync2.v
// Two-flop synchroniser for a bus of pin levels
`timescale 1ns/10ps
module pcr_sync2 #(
  parameter W = 8
) (
  // Clocking
  input wire ref_clk,
  input wire rst,
  input wire ce,
  // Data
  input wire [W-1:0] d,
  output reg [W-1:0] q
);
  reg [W-1:0] meta_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      meta_reg <= {W{1'b0}};
      q <= {W{1'b0}};
    end else if (ce) begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule

// File: design/pcr_top.v
// Control register bank of a 10/100 PHY with the logic those bits steer
// What this block does
// - Fast auto-negotiation picks a shortened link-fail-inhibit time: 50, 75, 150 ms.
// - Early receive-valid asserts on /J/; missing /K/ raises receive error.
// - Far-end link drop disables transmitter on link loss at 100 Mbps.
// - Fibre enable bit 14 resets from a strap input.
// - Fast parallel-detect bit selects shortened parallel-detect link-up.
// - Fast or robust crossover mode sets fast parallel-detect bit automatically.
// - Extended full duplex forces full duplex against forced 100BASE-TX partner.
// - Enhanced LED lights only on 100BASE-TX full duplex, no blinking.
// - MII isolation on 100BASE-TX half duplex or any 10BASE-Te link.
// - Idle symbol errors reported only when idle-error bit is one.
// - Odd-nibble end extends transmit enable one cycle with error set.
// - RMII receive data sampled on receive clock or crystal reference.
// - Fast crossover bit requests shortened MDI/MDIX resolution when forced.
//
// Register access over APB was left to the implementer.
`timescale 1ns/10ps
`include "pcr_regs.vh"
module pcr_top #(
  parameter LFI_CYC_0 = (`PCR_LFI_MS_0 * `PCR_CLK_KHZ),
  parameter LFI_CYC_1 = (`PCR_LFI_MS_1 * `PCR_CLK_KHZ),
  parameter LFI_CYC_2 = (`PCR_LFI_MS_2 * `PCR_CLK_KHZ),
  parameter LFI_CYC_STD = (`PCR_LFI_MS_STD * `PCR_CLK_KHZ)
) (
  // Clock, reset, enable
  input wire ref_clk,
  input wire rst,
  input wire ce,
  // Strap, sampled at reset release
  input wire strap_fx,
  // APB
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // Link state from the PHY core (same clock)
  input wire link_up,
  input wire speed_100,
  input wire full_duplex,
  input wire an_enabled,
  input wire partner_forced_100,
  input wire activity,
  input wire an_restart,
  // Receive symbol path (same clock)
  input wire sym_j,
  input wire sym_k,
  input wire sym_err,
  input wire line_idle,
  input wire rx_end,
  // Transmit path (same clock)
  input wire tx_en_in,
  input wire tx_odd_nibble,
  // Steering outputs
  output reg rx_dv,
  output reg rx_er,
  output reg tx_en_out,
  output reg tx_er_out,
  output reg tx_disable,
  output reg fx_mode,
  output reg fast_pd,
  output reg fast_mdix,
  output reg duplex_full,
  output reg led_link,
  output reg mii_isolate,
  output reg rmii_use_rxclk,
  output reg lfi_expired
);

  // ****************************************
  // Bus decode
  // ****************************************
  wire wr_ctrl1;
  wire wr_ctrl2;
  wire [1:0] rd_sel;
  wire rd_hit;
  pcr_apb_slave u_apb (
    .psel(psel),
    .penable(penable),
    .paddr(paddr),
    .pready(pready),
    .pslverr(pslverr),
    .wr_ctrl1(wr_ctrl1),
    .wr_ctrl2(wr_ctrl2),
    .rd_sel(rd_sel),
    .rd_hit(rd_hit),
    .pwrite(pwrite)
  );

  // Strap is a pin, so synchronise it first
  wire strap_fx_s;
  pcr_sync2 #(.W(1)) u_sync (
    .ref_clk(ref_clk),
    .rst(rst),
    .ce(ce),
    .d(strap_fx),
    .q(strap_fx_s)
  );

  // ****************************************
  // Control registers
  // ****************************************
  reg [15:0] ctrl1_reg;
  reg [15:0] ctrl2_reg;
  reg [1:0] strap_cnt_reg;
  wire [15:0] ctrl1_rd;
  wire auto_fast_pd;
  wire [15:0] wmask1;
  wire [15:0] wmask2;
  assign wmask1 = `PCR_C1_WMASK;
  assign wmask2 = `PCR_C2_WMASK;
  assign ctrl1_rd = ctrl1_reg & wmask1;
  assign auto_fast_pd = ctrl1_reg[`PCR_C1_FAST_MDIX] | ctrl1_reg[`PCR_C1_ROBUST_MDIX];

  always @(posedge ref_clk) begin
    if (rst) begin
      ctrl1_reg <= `PCR_C1_RESET;
      ctrl2_reg <= `PCR_C2_RESET;
      strap_cnt_reg <= `PCR_STRAP_WAIT;
    end else if (ce) begin
      if (wr_ctrl1)
        ctrl1_reg <= (ctrl1_reg & ~wmask1) | (pwdata[15:0] & wmask1);
      if (wr_ctrl2)
        ctrl2_reg <= (ctrl2_reg & ~wmask2) | (pwdata[15:0] & wmask2);
      // Strap loads fibre bit
      // Reset empties the synchroniser, so wait until it holds the pin level
      if (strap_cnt_reg != 2'h0)
        strap_cnt_reg <= strap_cnt_reg - 2'h1;
      if (strap_cnt_reg == 2'h1)
        ctrl2_reg[`PCR_C2_FX_EN] <= strap_fx_s;
      if (auto_fast_pd)
        ctrl2_reg[`PCR_C2_FAST_PD] <= 1'b1;
    end
  end

  // ****************************************
  // Read data
  // ****************************************
  wire [15:0] status_word;
  wire rd_setup;
  assign status_word = {9'h000, lfi_expired, rx_er, rx_dv, tx_disable, duplex_full,
    led_link, mii_isolate};
  // Captured in setup so the word already stands in the access phase
  assign rd_setup = psel & ~penable;
  always @(posedge ref_clk) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (ce) begin
      if (rd_setup & ~pwrite & rd_hit) begin
        case (rd_sel)
          2'h0: prdata <= {16'h0000, ctrl1_rd};
          2'h1: prdata <= {16'h0000, ctrl2_reg};
          2'h2: prdata <= {16'h0000, status_word};
          default: prdata <= {31'h00000000, link_up};
        endcase
      end else if (rd_setup) begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ****************************************
  // Link-fail-inhibit timer
  // ****************************************
  reg [31:0] lfi_cnt_reg;
  reg [31:0] lfi_limit;
  wire lfi_hold;
  wire lfi_last;
  // Any restart or link keeps the timer parked at zero
  assign lfi_hold = an_restart | link_up | ~an_enabled;
  assign lfi_last = (lfi_cnt_reg >= lfi_limit - 32'h00000001);
  always @* begin
    lfi_limit = LFI_CYC_STD;
    if (ctrl1_reg[`PCR_C1_FAST_AN]) begin
      case (ctrl1_reg[`PCR_C1_AN_SEL_HI:`PCR_C1_AN_SEL_LO])
        2'h0: lfi_limit = LFI_CYC_0;
        2'h1: lfi_limit = LFI_CYC_1;
        2'h2: lfi_limit = LFI_CYC_2;
        // Code 3 is undefined; keep the normal timer
        default: lfi_limit = LFI_CYC_STD;
      endcase
    end
  end
  always @(posedge ref_clk) begin
    if (rst) begin
      lfi_cnt_reg <= 32'h00000000;
      lfi_expired <= 1'b0;
    end else if (ce) begin
      if (lfi_hold) begin
        lfi_cnt_reg <= 32'h00000000;
        lfi_expired <= 1'b0;
      end else if (lfi_last) begin
        lfi_expired <= 1'b1;
      end else begin
        lfi_cnt_reg <= lfi_cnt_reg + 32'h00000001;
      end
    end
  end

  // ****************************************
  // Receive qualification
  // ****************************************
  localparam RX_IDLE = 3'h1;
  localparam RX_GOTJ = 3'h2;
  localparam RX_DATA = 3'h4;
  reg [2:0] rx_state_reg;
  always @(posedge ref_clk) begin
    if (rst) begin
      rx_state_reg <= RX_IDLE;
      rx_dv <= 1'b0;
      rx_er <= 1'b0;
    end else if (ce) begin
      rx_er <= 1'b0;
      case (rx_state_reg)
        RX_IDLE: begin
          if (sym_err & line_idle & ctrl2_reg[`PCR_C2_IDLE_ERR])
            rx_er <= 1'b1;
          if (sym_j) begin
            rx_state_reg <= RX_GOTJ;
            rx_dv <= ctrl1_reg[`PCR_C1_FAST_RXDV];
          end
        end
        RX_GOTJ: begin
          if (sym_k) begin
            rx_state_reg <= RX_DATA;
            rx_dv <= 1'b1;
          end else begin
            rx_state_reg <= RX_IDLE;
            rx_er <= ctrl1_reg[`PCR_C1_FAST_RXDV];
            rx_dv <= 1'b0;
          end
        end
        RX_DATA: begin
          if (sym_err)
            rx_er <= 1'b1;
          if (rx_end) begin
            rx_state_reg <= RX_IDLE;
            rx_dv <= 1'b0;
          end
        end
        default: begin
          rx_state_reg <= RX_IDLE;
          rx_dv <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************
  // Transmit path
  // ****************************************
  reg tx_en_d_reg;
  reg odd_d_reg;
  reg link_d_reg;
  wire odd_ext;
  wire far_drop_hit;
  // One extra cycle only, right after the last nibble of an odd frame
  assign odd_ext = tx_en_d_reg & odd_d_reg & ~ctrl2_reg[`PCR_C2_ODD_DIS];
  // Only a falling link at 100 Mbps drops the far end
  assign far_drop_hit = link_d_reg & speed_100 & ctrl2_reg[`PCR_C2_FAR_DROP];
  always @(posedge ref_clk) begin
    if (rst) begin
      tx_en_d_reg <= 1'b0;
      odd_d_reg <= 1'b0;
      link_d_reg <= 1'b0;
      tx_en_out <= 1'b0;
      tx_er_out <= 1'b0;
      tx_disable <= 1'b0;
    end else if (ce) begin
      tx_en_d_reg <= tx_en_in;
      odd_d_reg <= tx_odd_nibble;
      link_d_reg <= link_up;
      if (tx_en_in) begin
        tx_en_out <= 1'b1;
        tx_er_out <= 1'b0;
      end else if (odd_ext) begin
        tx_en_out <= 1'b1;
        tx_er_out <= 1'b1;
      end else begin
        tx_en_out <= 1'b0;
        tx_er_out <= 1'b0;
      end
      if (link_up)
        tx_disable <= 1'b0;
      else if (far_drop_hit)
        tx_disable <= 1'b1;
      else if (~ctrl2_reg[`PCR_C2_FAR_DROP])
        tx_disable <= 1'b0;
    end
  end

  // ****************************************
  // Mode outputs
  // ****************************************
  wire tx100;
  wire fd_eff;
  assign tx100 = speed_100 & ~ctrl2_reg[`PCR_C2_FX_EN];
  assign fd_eff = full_duplex |
    (ctrl2_reg[`PCR_C2_EXT_FD] & tx100 & partner_forced_100);
  always @(posedge ref_clk) begin
    if (rst) begin
      fx_mode <= 1'b0;
      fast_pd <= 1'b0;
      fast_mdix <= 1'b0;
      duplex_full <= 1'b0;
      led_link <= 1'b0;
      mii_isolate <= 1'b0;
      rmii_use_rxclk <= 1'b0;
    end else if (ce) begin
      fx_mode <= ctrl2_reg[`PCR_C2_FX_EN];
      fast_pd <= ctrl2_reg[`PCR_C2_FAST_PD];
      fast_mdix <= ctrl1_reg[`PCR_C1_FAST_MDIX] & ~an_enabled;
      duplex_full <= fd_eff;
      if (ctrl2_reg[`PCR_C2_LED_ENH])
        led_link <= link_up & tx100 & fd_eff;
      else
        led_link <= link_up & ~activity;
      mii_isolate <= ctrl2_reg[`PCR_C2_ISO_MII] & link_up &
        ((tx100 & ~fd_eff) | ~speed_100);
      rmii_use_rxclk <= ctrl2_reg[`PCR_C2_RMII_RXCLK];
    end
  end
endmodule

// File: tb/pcr_chk_properties.sv
// Port checker for the control register bank
`timescale 1ns/10ps
`include "pcr_regs.vh"
module pcr_chk (
  // Clock and reset
  input wire ref_clk,
  input wire rst,
  // Bus
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Link and transmit
  input wire link_up,
  input wire speed_100,
  input wire full_duplex,
  input wire tx_en_in,
  input wire tx_en_out,
  input wire tx_er_out,
  // Steering
  input wire fx_mode,
  input wire rmii_use_rxclk,
  input wire led_link,
  input wire mii_isolate
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire acc = psel && penable;
  wire map = paddr == `PCR_ADDR_CTRL1 || paddr == `PCR_ADDR_CTRL2
    || paddr == `PCR_ADDR_STATUS || paddr == `PCR_ADDR_LINK;
  wire wr2 = acc && pwrite && paddr == `PCR_ADDR_CTRL2;
  a_ready_always: assert property (pready) else $error("pready low");
  a_err_unmapped: assert property (acc |-> pslverr == !map)
    else $error("pslverr wrong");
  a_read_upper: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read data set");
  a_c1_reserved: assert property (acc && !pwrite && paddr == `PCR_ADDR_CTRL1
    |-> prdata[15:7] == 9'h000 && !prdata[0]) else $error("reserved bits set");
  a_fx_write: assert property (wr2 |-> ##2 fx_mode == $past(pwdata[14], 2))
    else $error("fibre mode wrong");
  a_rxclk_write: assert property (wr2 |-> ##2 rmii_use_rxclk == $past(pwdata[0], 2))
    else $error("receive clock select wrong");
  a_tx_follow: assert property (tx_en_in |=> tx_en_out)
    else $error("tx enable lost");
  a_tx_one_ext: assert property (!tx_en_in && !$past(tx_en_in) |=> !tx_en_out)
    else $error("tx enable extended too long");
  a_tx_er_ext: assert property (tx_er_out |-> tx_en_out && !$past(tx_en_in)
    && $past(tx_en_in, 2)) else $error("tx error outside extension");
  a_led_link: assert property (led_link |-> $past(link_up))
    else $error("led without link");
  a_iso_cause: assert property (mii_isolate |-> $past(link_up)
    && !($past(speed_100) && $past(full_duplex))) else $error("isolation wrong");
endmodule

// File: tb/pcr_mac_model.sv
// Transmit side of the MAC: sends frames and tallies extension cycles
`timescale 1ns/10ps
module pcr_mac_model (
  // Clock
  input wire ref_clk,
  input wire rst,
  // Command
  input wire go,
  input wire [7:0] len,
  input wire odd,
  // Transmit path
  output reg tx_en,
  output reg odd_nib,
  input wire tx_en_out,
  input wire tx_er_out,
  // Tallies
  output reg [7:0] en_cnt,
  output reg [7:0] er_cnt
);
  // ****************************************
  // Frame engine
  // ****************************************
  reg [7:0] left_reg;
  always @(posedge ref_clk) begin
    if (rst || go) begin
      left_reg <= rst ? 8'h00 : len;
      en_cnt <= 8'h00;
      er_cnt <= 8'h00;
    end else begin
      if (left_reg != 8'h00) begin
        left_reg <= left_reg - 8'h01;
      end
      en_cnt <= en_cnt + {7'h00, tx_en_out};
      er_cnt <= er_cnt + {7'h00, tx_er_out};
    end
  end
  always @* begin
    tx_en = left_reg != 8'h00;
    odd_nib = odd && left_reg == 8'h01;
  end
endmodule

// File: tb/testbench.sv
// Self-checking bench for the control register bank
`timescale 1ns/10ps
`include "pcr_regs.vh"
module testbench;
  // ****************************************
  // Signals and instances
  // ****************************************
  reg ref_clk = 0, rst = 1, strap_fx = 1, psel = 0, penable = 0, pwrite = 0;
  reg [11:0] paddr = 0;
  reg [31:0] pwdata = 0, r, d;
  reg link_up = 0, speed_100 = 0, full_duplex = 0, an_enabled = 0, partner_forced_100 = 0;
  reg activity = 0, an_restart = 0, sym_j = 0, sym_k = 0, sym_err = 0, line_idle = 0;
  reg rx_end = 0, go = 0, odd = 0, ce = 1, e, x, f;
  reg [7:0] len = 0;
  reg [15:0] e1, e2;
  wire [31:0] prdata;
  wire [7:0] en_cnt, er_cnt;
  wire pready, pslverr, tx_en_in, tx_odd_nibble, rx_dv, rx_er, tx_en_out, tx_er_out;
  wire tx_disable, fx_mode, fast_pd, fast_mdix, duplex_full, led_link, mii_isolate;
  wire rmii_use_rxclk, lfi_expired;
  integer seed, i, n, n_errors = 0, check_count = 0;
  integer lfi [0:3] = '{20, 30, 60, 300};
  localparam [11:0] a1 = `PCR_ADDR_CTRL1;
  localparam [11:0] a2 = `PCR_ADDR_CTRL2;
  always #25 ref_clk = ~ref_clk;
  // Short timer counts keep the run brief
  pcr_top #(.LFI_CYC_0(20), .LFI_CYC_1(30), .LFI_CYC_2(60), .LFI_CYC_STD(300)) dut (
    .ce(ce), .*);
  pcr_mac_model mac (.ref_clk, .rst, .go, .len, .odd, .tx_en(tx_en_in),
    .odd_nib(tx_odd_nibble), .tx_en_out, .tx_er_out, .en_cnt, .er_cnt);
  // ****************************************
  // Tasks
  // ****************************************
  task summarize;
    begin
      if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count++;
      if (got !== exp) begin
        n_errors++;
        $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Idle edge after each transfer keeps strobes from toggling twice
  task apb(input w, input [11:0] a, input [31:0] wd);
    begin
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge ref_clk) penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
    end
  endtask
  task wr1(input [15:0] v);
    begin
      apb(1, a1, {d[31:16], v});
      e1 = v & `PCR_C1_WMASK;
      if (e1[6] | e1[5]) e2[6] = 1;
    end
  endtask
  task wr2(input [15:0] v);
    begin
      apb(1, a2, {16'h0000, v});
      e2 = (v & `PCR_C2_WMASK) | `PCR_C2_RESET | {9'h000, |e1[6:5], 6'h00};
    end
  endtask
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    seed = 57689;
    repeat (3) @(posedge ref_clk);
    rst <= 0;
    repeat (6) @(posedge ref_clk);
    apb(0, a1, 0);
    chk(r, 0);
    apb(0, a2, 0);
    chk(r, 32'h4100);
    e1 = 0;
    e2 = 16'h4100;
    for (i = 0; i < 40; i++) begin
      d = $random(seed);
      if (d[31]) wr2(d[15:0]);
      else wr1(d[15:0]);
      apb(0, a1, 0);
      chk(r, e1);
      apb(0, a2, 0);
      chk(r, e2);
      chk({fx_mode, rmii_use_rxclk, fast_mdix, fast_pd}, {e2[14], e2[0], e1[6], e2[6]});
    end
    apb(1, 12'h02C, 32'hFFFF);
    chk(e, 1);
    apb(0, 12'h02C, 0);
    chk({31'h0, e}, 1);
    chk(r, 0);
    for (i = 0; i < 24; i++) begin
      d = $random(seed);
      if (i % 8 == 0) wr2(d[15:0] & 16'h0038);
      {link_up, speed_100, full_duplex, activity, an_enabled, partner_forced_100} <= d[21:16];
      repeat (3) @(posedge ref_clk);
      f = full_duplex | (e2[5] & speed_100 & partner_forced_100);
      chk(led_link, e2[4] ? link_up & speed_100 & f : link_up & ~activity);
      chk({mii_isolate, tx_disable}, {e2[3] & link_up & ~(speed_100 & f), 1'b0});
      chk(duplex_full, f);
    end
    for (i = 0; i < 3; i++) begin
      wr2(i == 2 ? 16'h0002 : 16'h0000);
      x = i == 0;
      odd <= i != 1;
      len <= 8'h05 + i[7:0];
      go <= 1;
      @(posedge ref_clk) go <= 0;
      repeat (20) @(posedge ref_clk);
      chk({en_cnt, er_cnt}, {len + {7'h00, x}, 7'h00, x});
    end
    for (i = 0; i < 4; i++) begin
      x = i % 2;
      if (i < 2) wr1({14'h0, x, 1'b0});
      else wr2({13'h0, x, 2'b0});
      line_idle <= i > 1;
      if (i < 2) sym_j <= 1;
      else sym_err <= 1;
      @(posedge ref_clk) {sym_j, sym_err} <= 2'b00;
      n = 0;
      e = 0;
      repeat (6) @(posedge ref_clk) begin
        n += rx_er;
        e = e | rx_dv;
      end
      chk(n != 0, x);
      chk(e, i == 1);
    end
    wr2(16'h8000);
    {speed_100, link_up} <= 2'b11;
    repeat (3) @(posedge ref_clk) link_up <= 0;
    repeat (3) @(posedge ref_clk);
    chk(tx_disable, 1);
    ce <= 0;
    link_up <= 1;
    repeat (3) @(posedge ref_clk);
    chk(tx_disable, 1);
    ce <= 1;
    repeat (2) @(posedge ref_clk);
    chk(tx_disable, 0);
    link_up <= 0;
    for (i = 0; i < 4; i++) begin
      wr1({12'h001, i[1:0], 2'b00});
      {an_enabled, an_restart} <= 2'b11;
      @(posedge ref_clk) an_restart <= 0;
      @(posedge ref_clk);
      n = 1;
      while (lfi_expired !== 1'b1 && n < 400) @(posedge ref_clk) n++;
      chk(n >= lfi[i] - 2 && n <= lfi[i] + 3, 1);
    end
    summarize;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_errors++;
    summarize;
  end
endmodule
bind pcr_top pcr_chk u_chk (.ref_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
  .prdata, .pready, .pslverr, .link_up, .speed_100, .full_duplex, .tx_en_in, .tx_en_out,
  .tx_er_out, .fx_mode, .rmii_use_rxclk, .led_link, .mii_isolate);
